/* rtl/cmp_ctrl.sv */
/*
 control logic for two analog comparators: configuration, result conditioning,
 timer sync, edge interrupt flags, pin and pwm routing, behind an axi4-lite slave.
 assumes the raw comparator decisions and timer clock arrive asynchronously.
*/
// What this block does
// RQ1: speed_power_select resets to one; zero selects low power, slower mode.
// RQ2: hysteresis_enable adds input hysteresis; clearing it removes it.
// RQ3: each result is offered to the gate_timer as a gate source.
// RQ4: with sync_to_timer, timer and pin result latch on timer clock fall.
// RQ5: with prescaler in use, the capture uses the prescaler output clock.
// RQ6: gate_timer counts on rising clock edge, opposite to result capture.
// RQ7: software should enable sync when a comparator gates the timer.
// RQ8: rise and fall detectors per unit set the flag when enabled.
// RQ9: only software clears the flag; an edge during clear wins.
// RQ10: software sets enables, polarity, speed and irq enables for interrupts.
// RQ11: toggling enable, or invert while enabled, still produces result edges; an invert toggle while disabled leaves result at zero.
// RQ12: two-bit positive select routes pin, dac, fixed_reference or ground.
// RQ13: with comparator disabled every input multiplexer path is open.
// RQ14: three-bit negative select routes one defined source to inverting input.
// RQ15: consumers treat result as indeterminate after input or reference change.
// RQ16: each result routes to its pin and to the pwm shutdown input.
// RQ17: software confirms result after initialisation before relying on it.
// RQ18: port reads return zero for pins set as analog inputs.
// RQ19: result high when positive exceeds negative; invert flips it.
// RQ20: positive encodings 00 pin, 01 dac, 10 fixed_reference, 11 ground.
// RQ21: negative 001-011 pins, 100 fixed_reference; others reserved.
// RQ22: result forced to zero while comparator disabled.
`timescale 1ns/1ps
module cmp_ctrl (
    // clock and reset
    input  wire logic                         CLK_SYS_IN,
    input  wire logic                         RESETN_IN,
    // axi4-lite write
    input  wire logic [7:0]                   AWADDR_IN,
    input  wire logic                         AWVALID_IN,
    output logic                              AWREADY_OUT,
    input  wire logic [31:0]                  WDATA_IN,
    input  wire logic [3:0]                   WSTRB_IN,
    input  wire logic                         WVALID_IN,
    output logic                              WREADY_OUT,
    output logic [1:0]                        BRESP_OUT,
    output logic                              BVALID_OUT,
    input  wire logic                         BREADY_IN,
    // axi4-lite read
    input  wire logic [7:0]                   ARADDR_IN,
    input  wire logic                         ARVALID_IN,
    output logic                              ARREADY_OUT,
    output logic [31:0]                       RDATA_OUT,
    output logic [1:0]                        RRESP_OUT,
    output logic                              RVALID_OUT,
    input  wire logic                         RREADY_IN,
    // analog side: raw decisions (positive above negative) and controls
    input  wire logic [1:0]                   RAW_DECISION_IN,
    output cmp_ctrl_pkg::analog_ctl_t [1:0]   ANALOG_CTL_OUT,
    // gate timer clock, after its prescaler when one is used
    input  wire logic                         TIMER_CLK_IN,
    // pins
    input  wire logic [cmp_ctrl_pkg::PIN_W-1:0] PIN_LEVEL_IN,
    input  wire logic [1:0]                   PIN_DIR_INPUT_IN,
    output logic [1:0]                        RESULT_PIN_OUT,
    output logic [1:0]                        RESULT_PIN_OE_OUT,
    // results to timer, pwm shutdown and interrupt controller
    output logic [1:0]                        TIMER_GATE_OUT,
    output logic [1:0]                        PWM_SHUTDOWN_OUT,
    output logic [1:0]                        IRQ_REQ_OUT
);
    // ==========================================================
    // state
    typedef struct packed {
        cmp_ctrl_pkg::unit_cfg_t [1:0]   cfg;
        logic [1:0]                      irq_flag;
        logic [1:0]                      irq_ena;
        logic [cmp_ctrl_pkg::PIN_W-1:0]  analog_pin_select;
        logic [1:0]                      raw_s1;
        logic [1:0]                      raw_s2;
        logic [1:0]                      tclk_s1;
        logic [1:0]                      tclk_s2;
        logic [1:0]                      tclk_s3;
        logic [1:0]                      result;
        logic [1:0]                      result_d;
        logic [1:0]                      synced;
        logic [cmp_ctrl_pkg::PIN_W-1:0]  pin_s1;
        logic [cmp_ctrl_pkg::PIN_W-1:0]  pin_s2;
        logic [7:0]                      aw_addr;
        logic                            aw_held;
        logic [31:0]                     w_data;
        logic                            w_held;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [31:0]                     rdata;
        cmp_ctrl_pkg::analog_ctl_t [1:0] actl;
        logic [1:0]                      pin_out;
        logic [1:0]                      pin_oe;
        logic [1:0]                      gate;
        logic [1:0]                      irq_req;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a,
                                             output logic hit);
        logic [31:0] v;
        v   = 32'h0;
        hit = 1'b1;
        if (a == cmp_ctrl_pkg::CTRL_A_OFS || a == cmp_ctrl_pkg::CTRL_A_OFS +
            cmp_ctrl_pkg::UNIT_STRIDE) begin
            v = ctrl_a_word(s.cfg[a[3]], s.result[a[3]]);
        end else if (a == cmp_ctrl_pkg::CTRL_B_OFS || a == cmp_ctrl_pkg::CTRL_B_OFS +
                     cmp_ctrl_pkg::UNIT_STRIDE) begin
            v[cmp_ctrl_pkg::B_RISE]                       = s.cfg[a[3]].rise_en;
            v[cmp_ctrl_pkg::B_FALL]                       = s.cfg[a[3]].fall_en;
            v[cmp_ctrl_pkg::B_PSEL +: 2]                  = s.cfg[a[3]].psel;
            v[cmp_ctrl_pkg::B_NSEL +: 3]                  = s.cfg[a[3]].nsel;
        end else if (a == cmp_ctrl_pkg::RESULT_OFS) begin
            v[1:0] = s.result;
        end else if (a == cmp_ctrl_pkg::IRQ_FLG_OFS) begin
            v[1:0] = s.irq_flag;
        end else if (a == cmp_ctrl_pkg::IRQ_ENA_OFS) begin
            v[1:0] = s.irq_ena;
        end else if (a == cmp_ctrl_pkg::PORT_OFS) begin
            v[cmp_ctrl_pkg::PIN_W-1:0] = s.pin_s2 & ~s.analog_pin_select;   // [RQ18]
        end else if (a == cmp_ctrl_pkg::ANALOG_PIN_SELECT_OFS) begin
            v[cmp_ctrl_pkg::PIN_W-1:0] = s.analog_pin_select;
        end else begin
            hit = 1'b0;
        end
        return v;
    endfunction

    function automatic logic [31:0] ctrl_a_word(input cmp_ctrl_pkg::unit_cfg_t c,
                                                input logic r);
        logic [31:0] v;
        v                          = 32'h0;
        v[cmp_ctrl_pkg::A_ENABLE]  = c.enable;
        v[cmp_ctrl_pkg::A_RESULT]  = r;
        v[cmp_ctrl_pkg::A_OE]      = c.oe;
        v[cmp_ctrl_pkg::A_INVERT]  = c.invert;
        v[cmp_ctrl_pkg::A_SPEED]   = c.speed;
        v[cmp_ctrl_pkg::A_HYST]    = c.hyst;
        v[cmp_ctrl_pkg::A_SYNC]    = c.sync;
        return v;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic       do_wr;
        logic       hit;
        logic [7:0] wa;
        logic [1:0] clr;
        logic [1:0] edge_hit;
        logic [1:0] tfall;
        nxt_state = state_ff;
        do_wr     = 1'b0;
        hit       = 1'b0;
        wa        = 8'h0;
        clr       = 2'h0;
        edge_hit  = 2'h0;
        tfall     = 2'h0;

        nxt_state.raw_s1  = RAW_DECISION_IN;
        nxt_state.raw_s2  = state_ff.raw_s1;
        nxt_state.tclk_s1 = {2{TIMER_CLK_IN}};
        nxt_state.tclk_s2 = state_ff.tclk_s1;
        nxt_state.tclk_s3 = state_ff.tclk_s2;
        nxt_state.pin_s1  = PIN_LEVEL_IN;
        nxt_state.pin_s2  = state_ff.pin_s1;

        // axi write: address and data may come in either order
        if (AWVALID_IN && !state_ff.aw_held) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = AWADDR_IN;
        end
        if (WVALID_IN && !state_ff.w_held) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = WDATA_IN;
        end
        if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid) begin
            do_wr             = 1'b1;
            wa                = state_ff.aw_addr;
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held  = 1'b0;
            nxt_state.bvalid  = 1'b1;
            void'(read_reg(state_ff, wa, hit));
            nxt_state.bresp   = hit ? cmp_ctrl_pkg::RESP_OKAY : cmp_ctrl_pkg::RESP_SLVERR;
        end
        if (state_ff.bvalid && BREADY_IN) begin
            nxt_state.bvalid = 1'b0;
        end
        // byte lane 0 carries every field; other lanes hold nothing
        if (do_wr && hit) begin
            for (int u = 0; u < 2; u++) begin
                if (wa == 8'(cmp_ctrl_pkg::CTRL_A_OFS + u * cmp_ctrl_pkg::UNIT_STRIDE)) begin
                    nxt_state.cfg[u].enable = state_ff.w_data[cmp_ctrl_pkg::A_ENABLE];
                    nxt_state.cfg[u].oe     = state_ff.w_data[cmp_ctrl_pkg::A_OE];
                    nxt_state.cfg[u].invert = state_ff.w_data[cmp_ctrl_pkg::A_INVERT];
                    nxt_state.cfg[u].speed  = state_ff.w_data[cmp_ctrl_pkg::A_SPEED];  // [RQ1]
                    nxt_state.cfg[u].hyst   = state_ff.w_data[cmp_ctrl_pkg::A_HYST];   // [RQ2]
                    nxt_state.cfg[u].sync   = state_ff.w_data[cmp_ctrl_pkg::A_SYNC];
                end
                if (wa == 8'(cmp_ctrl_pkg::CTRL_B_OFS + u * cmp_ctrl_pkg::UNIT_STRIDE)) begin
                    nxt_state.cfg[u].rise_en = state_ff.w_data[cmp_ctrl_pkg::B_RISE];
                    nxt_state.cfg[u].fall_en = state_ff.w_data[cmp_ctrl_pkg::B_FALL];
                    nxt_state.cfg[u].psel    = state_ff.w_data[cmp_ctrl_pkg::B_PSEL +: 2];
                    nxt_state.cfg[u].nsel    = state_ff.w_data[cmp_ctrl_pkg::B_NSEL +: 3];
                end
            end
            if (wa == cmp_ctrl_pkg::IRQ_FLG_OFS) begin
                clr = state_ff.w_data[1:0];
            end
            if (wa == cmp_ctrl_pkg::IRQ_ENA_OFS) begin
                nxt_state.irq_ena = state_ff.w_data[1:0];
            end
            if (wa == cmp_ctrl_pkg::ANALOG_PIN_SELECT_OFS) begin
                nxt_state.analog_pin_select = state_ff.w_data[cmp_ctrl_pkg::PIN_W-1:0];
            end
        end

        // axi read
        if (ARVALID_IN && !state_ff.rvalid) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata  = read_reg(state_ff, ARADDR_IN, hit);
            nxt_state.rresp  = hit ? cmp_ctrl_pkg::RESP_OKAY : cmp_ctrl_pkg::RESP_SLVERR;
        end else if (state_ff.rvalid && RREADY_IN) begin
            nxt_state.rvalid = 1'b0;
        end

        for (int u = 0; u < 2; u++) begin
            // disabled forces zero, so an enable toggle, or an invert toggle while enabled, still yields an edge
            nxt_state.result[u] = state_ff.cfg[u].enable &
                                  (state_ff.raw_s2[u] ^ state_ff.cfg[u].invert); // [RQ19] [RQ22] [RQ11]
            nxt_state.result_d[u] = state_ff.result[u];
            edge_hit[u] = (state_ff.cfg[u].rise_en & state_ff.result[u] & ~state_ff.result_d[u]) |
                          (state_ff.cfg[u].fall_en & ~state_ff.result[u] & state_ff.result_d[u]); // [RQ8]
            // set wins over a clearing write in the same cycle
            nxt_state.irq_flag[u] = edge_hit[u] | (state_ff.irq_flag[u] & ~clr[u]); // [RQ9]
            // timer clock falling edge, which may be the prescaled clock;
            // taken past the second stage so the first stage feeds nothing else
            tfall[u] = state_ff.tclk_s3[u] & ~state_ff.tclk_s2[u];                 // [RQ5]
            if (!state_ff.cfg[u].sync) begin
                nxt_state.synced[u] = state_ff.result[u];
            end else if (tfall[u]) begin
                nxt_state.synced[u] = state_ff.result[u];                          // [RQ4] [RQ6]
            end
            nxt_state.gate[u]    = state_ff.synced[u];                             // [RQ3]
            nxt_state.pin_out[u] = state_ff.synced[u];                             // [RQ16]
            nxt_state.pin_oe[u]  = state_ff.cfg[u].oe & ~PIN_DIR_INPUT_IN[u];
            nxt_state.irq_req[u] = state_ff.irq_flag[u] & state_ff.irq_ena[u];
            nxt_state.actl[u].enable = state_ff.cfg[u].enable;
            nxt_state.actl[u].speed  = state_ff.cfg[u].speed;
            nxt_state.actl[u].hyst   = state_ff.cfg[u].hyst;
            nxt_state.actl[u].pos_mux = 4'h0;
            nxt_state.actl[u].neg_mux = 4'h0;
            if (state_ff.cfg[u].enable) begin                                      // [RQ13]
                nxt_state.actl[u].pos_mux[state_ff.cfg[u].psel] = 1'b1;            // [RQ12] [RQ20]
                unique case (state_ff.cfg[u].nsel)                                 // [RQ14] [RQ21]
                    cmp_ctrl_pkg::NSEL_IN1: nxt_state.actl[u].neg_mux = 4'h1;
                    cmp_ctrl_pkg::NSEL_IN2: nxt_state.actl[u].neg_mux = 4'h2;
                    cmp_ctrl_pkg::NSEL_IN3: nxt_state.actl[u].neg_mux = 4'h4;
                    cmp_ctrl_pkg::NSEL_FVR: nxt_state.actl[u].neg_mux = 4'h8;
                    default:                nxt_state.actl[u].neg_mux = 4'h0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_ff             <= '0;
            state_ff.cfg[0].speed <= cmp_ctrl_pkg::SPEED_RST;                     // [RQ1]
            state_ff.cfg[1].speed <= cmp_ctrl_pkg::SPEED_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs
    assign AWREADY_OUT       = ~state_ff.aw_held;
    assign WREADY_OUT        = ~state_ff.w_held;
    assign BVALID_OUT        = state_ff.bvalid;
    assign BRESP_OUT         = state_ff.bresp;
    assign ARREADY_OUT       = ~state_ff.rvalid;
    assign RVALID_OUT        = state_ff.rvalid;
    assign RDATA_OUT         = state_ff.rdata;
    assign RRESP_OUT         = state_ff.rresp;
    assign ANALOG_CTL_OUT    = state_ff.actl;
    assign RESULT_PIN_OUT    = state_ff.pin_out;
    assign RESULT_PIN_OE_OUT = state_ff.pin_oe;
    assign TIMER_GATE_OUT    = state_ff.gate;
    assign PWM_SHUTDOWN_OUT  = state_ff.result_d;                                 // [RQ16]
    assign IRQ_REQ_OUT       = state_ff.irq_req;

    // ==========================================================
    // checks
    property p_flag_set;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        (state_ff.cfg[0].rise_en && state_ff.result[0] && !state_ff.result_d[0])
            |=> state_ff.irq_flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("rise edge did not set flag"); // [RQ8]

    wire do_clear_any = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid &&
                        state_ff.aw_addr == cmp_ctrl_pkg::IRQ_FLG_OFS;
    property p_flag_hold;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        (state_ff.irq_flag[0] && !(do_clear_any)) |=> state_ff.irq_flag[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware"); // [RQ9]

    property p_off_zero;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        !state_ff.cfg[0].enable ##1 !state_ff.cfg[0].enable |-> !state_ff.result[0];
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("disabled result not zero"); // [RQ22]

    property p_mux_open;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        !state_ff.cfg[1].enable |=> (state_ff.actl[1].pos_mux == 4'h0 &&
                                     state_ff.actl[1].neg_mux == 4'h0);
    endproperty
    a_mux_open: assert property (p_mux_open) else $error("mux path left open"); // [RQ13]

    property p_sync_hold;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        (state_ff.cfg[0].sync && $past(state_ff.cfg[0].sync) &&
         !(state_ff.tclk_s3[0] && !state_ff.tclk_s2[0])) |=> $stable(state_ff.synced[0]);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("synced result moved off edge"); // [RQ4]

    property p_polarity;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        state_ff.cfg[0].enable |=> state_ff.result[0] ==
                                   ($past(state_ff.raw_s2[0]) ^ $past(state_ff.cfg[0].invert));
    endproperty
    a_polarity: assert property (p_polarity) else $error("result polarity wrong"); // [RQ19]

    property p_speed_reset;
        @(posedge CLK_SYS_IN) $rose(RESETN_IN) |-> state_ff.cfg[1].speed;
    endproperty
    a_speed_reset: assert property (p_speed_reset) else $error("speed bit not one at reset"); // [RQ1]

    property p_gate_follow;
        @(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
        !$past(state_ff.cfg[1].sync) |=> TIMER_GATE_OUT[1] == $past(state_ff.result[1], 2) &&
                                         RESULT_PIN_OUT[1] == $past(state_ff.result[1], 2);
    endproperty
    a_gate_follow: assert property (p_gate_follow) else $error("gate or pin not from result"); // [RQ3]
endmodule // cmp_ctrl

/* rtl/cmp_ctrl_pkg.sv */
/*
 register map, field positions, reset values and carriers for the comparator control block.
 assumes an axi4-lite master with 32-bit data and one clock.
*/
package cmp_ctrl_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] CTRL_A_OFS  = 8'h00;   // comparator_control_a, unit 0
    localparam logic [7:0] CTRL_B_OFS  = 8'h04;   // comparator_control_b, unit 0
    localparam logic [7:0] UNIT_STRIDE = 8'h08;   // unit 1 at +8
    localparam logic [7:0] RESULT_OFS  = 8'h10;   // mirror of both results
    localparam logic [7:0] IRQ_FLG_OFS = 8'h14;   // irq_flag_register, write 1 clears
    localparam logic [7:0] IRQ_ENA_OFS = 8'h18;   // irq_enable_register
    localparam logic [7:0] PORT_OFS    = 8'h1C;   // port readback
    localparam logic [7:0] ANALOG_PIN_SELECT_OFS   = 8'h20;   // analog_pin_select
    // ==========================================================
    // control a fields
    localparam int A_ENABLE = 7;
    localparam int A_RESULT = 6;
    localparam int A_OE     = 5;
    localparam int A_INVERT = 4;
    localparam int A_SPEED  = 2;
    localparam int A_HYST   = 1;
    localparam int A_SYNC   = 0;
    // control b fields
    localparam int B_RISE   = 7;
    localparam int B_FALL   = 6;
    localparam int B_PSEL   = 4;
    localparam int B_NSEL   = 0;
    localparam logic SPEED_RST = 1'b1;
    localparam int   PIN_W     = 8;
    // ==========================================================
    // input selects
    localparam logic [1:0] PSEL_PIN = 2'h0;
    localparam logic [1:0] PSEL_DAC = 2'h1;
    localparam logic [1:0] PSEL_FVR = 2'h2;
    localparam logic [1:0] PSEL_GND = 2'h3;
    localparam logic [2:0] NSEL_IN1 = 3'h1;
    localparam logic [2:0] NSEL_IN2 = 3'h2;
    localparam logic [2:0] NSEL_IN3 = 3'h3;
    localparam logic [2:0] NSEL_FVR = 3'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enable;
        logic       oe;
        logic       invert;
        logic       speed;
        logic       hyst;
        logic       sync;
        logic       rise_en;
        logic       fall_en;
        logic [1:0] psel;
        logic [2:0] nsel;
    } unit_cfg_t;

    // analog-side control per comparator
    typedef struct packed {
        logic       enable;
        logic       speed;
        logic       hyst;
        logic [3:0] pos_mux;   // one-hot, zero = disconnected
        logic [3:0] neg_mux;   // one-hot in1,in2,in3,fvr
    } analog_ctl_t;
endpackage : cmp_ctrl_pkg

/* dv/cmp_partner.sv */
/*
 far side model: analog decisions and the gate timer clock.
 assumes the bench sets the wanted decisions and when the timer runs.
*/
`timescale 1ns/1ps
module cmp_partner (
    input  wire logic [1:0] want_in,
    input  wire logic       run_in,
    output logic [1:0]      raw_out,
    output logic            tclk_out
);
    assign raw_out = want_in;
    // timer clock stands low while stopped; its period is unrelated to the system clock
    initial begin
        tclk_out = 1'b0;
        forever begin
            #17.3;
            tclk_out = run_in ? ~tclk_out : 1'b0;
        end
    end
endmodule // cmp_partner

/* dv/analog_comparator_control_tb.sv */
/*
 self-checking bench for cmp_ctrl over axi4-lite.
 assumes flag, enable and result registers hold unit 0 in bit 0.
*/
`timescale 1ns/1ps
module analog_comparator_control_tb;
    logic clk, rst_n, awv, wv, br, arv, rr, run, awr, wrd, bv, arr, rv, tclk, en, sp, hy;
    logic [7:0] awa, ara, pins, an, of;
    logic [31:0] wd, rd, rdata, cv;
    logic [1:0] want, dir, rsp, bresp, rresp, raw, pin, oe, gate, pwm, irq;
    cmp_ctrl_pkg::analog_ctl_t [1:0] ctl;
    cmp_ctrl_pkg::analog_ctl_t       ec;
    int errors, comparisons, u;
    cmp_partner u_cmp_partner (.want_in(want), .run_in(run), .raw_out(raw), .tclk_out(tclk));
    cmp_ctrl u_cmp_ctrl (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .AWADDR_IN(awa),
        .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'hF),
        .WVALID_IN(wv), .WREADY_OUT(wrd), .BRESP_OUT(bresp), .BVALID_OUT(bv),
        .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rr),
        .RAW_DECISION_IN(raw), .ANALOG_CTL_OUT(ctl), .TIMER_CLK_IN(tclk),
        .PIN_LEVEL_IN(pins), .PIN_DIR_INPUT_IN(dir), .RESULT_PIN_OUT(pin),
        .RESULT_PIN_OE_OUT(oe), .TIMER_GATE_OUT(gate), .PWM_SHUTDOWN_OUT(pwm),
        .IRQ_REQ_OUT(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // requests change just after an edge and each valid stands until the edge that accepts it, then the task waits for the answer;
    // bready and rready stay high for the whole run
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic tb;
        int n;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        tb = 1'b0;
        n = 0;
        while (!tb && n < 100) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            tb = bv && br;
            rsp = bresp;
            n++;
        end
        if (!tb) errors++;
    endtask
    task automatic rdr(input logic [7:0] a);
        logic tr;
        int n;
        ara <= a;
        arv <= 1'b1;
        tr = 1'b0;
        n = 0;
        while (!tr && n < 100) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            tr = rv && rr;
            rd = rdata;
            rsp = rresp;
            n++;
        end
        if (!tr) errors++;
    endtask
    function automatic cmp_ctrl_pkg::analog_ctl_t exp_ctl(logic e, logic s, logic h,
                                                          logic [1:0] ps, logic [2:0] ns);
        exp_ctl = '0;
        exp_ctl.enable = e; exp_ctl.speed = s; exp_ctl.hyst = h;
        if (e) begin
            exp_ctl.pos_mux = 4'h1 << ps;
            if (ns inside {[1:4]}) exp_ctl.neg_mux = 4'h1 << (ns - 1);
        end
    endfunction
    initial begin
        rst_n = 1'b0;
        awv = 1'b0;
        wv = 1'b0;
        br = 1'b1;
        arv = 1'b0;
        rr = 1'b1;
        run = 1'b0;
        awa = '0;
        ara = '0;
        wd = '0;
        want = '0;
        dir = '0;
        pins = '0;
        void'($urandom(32'h8316fce3));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdr(cmp_ctrl_pkg::CTRL_A_OFS);
        chk("ctrl_a reset", rd, 32'h04);
        rdr(8'h24);
        chk("unmapped rresp", rsp, cmp_ctrl_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            u = $urandom % 2;
            en = (i != 3);
            sp = $urandom;
            hy = $urandom;
            of = u ? cmp_ctrl_pkg::UNIT_STRIDE : 8'h00;
            cv = (32'(en) << cmp_ctrl_pkg::A_ENABLE) | (32'(sp) << cmp_ctrl_pkg::A_SPEED);
            wr(cmp_ctrl_pkg::CTRL_A_OFS + of, cv | (32'(hy) << cmp_ctrl_pkg::A_HYST));
            wr(cmp_ctrl_pkg::CTRL_B_OFS + of, (32'(i % 4) << cmp_ctrl_pkg::B_PSEL) | 32'(i));
            repeat (2) @(posedge clk);
            ec = exp_ctl(en, sp, hy, 2'(i), 3'(i));
            chk("analog ctl", ctl[u], ec);
        end
        // interrupt path set up the way software must do it
        wr(cmp_ctrl_pkg::CTRL_B_OFS, 32'h81);
        wr(cmp_ctrl_pkg::IRQ_ENA_OFS, 32'h1);
        wr(cmp_ctrl_pkg::IRQ_FLG_OFS, 32'h3);
        wr(cmp_ctrl_pkg::CTRL_A_OFS, 32'hA0);
        want <= 2'b01;
        repeat (8) @(posedge clk);
        chk("gate", gate[0], 1'b1);
        chk("pwm and pin", {pwm[0], pin[0], oe[0]}, 3'b111);
        dir <= 2'b01;
        repeat (2) @(posedge clk);
        chk("pin oe as input", oe[0], 1'b0);
        dir <= 2'b00;
        chk("irq req", irq[0], 1'b1);
        rdr(cmp_ctrl_pkg::RESULT_OFS);
        chk("result", rd[0], 1'b1);
        rdr(cmp_ctrl_pkg::IRQ_FLG_OFS);
        chk("flag set", rd[0], 1'b1);
        wr(cmp_ctrl_pkg::IRQ_FLG_OFS, 32'h1);
        rdr(cmp_ctrl_pkg::IRQ_FLG_OFS);
        chk("flag clear", rd[0], 1'b0);
        wr(cmp_ctrl_pkg::CTRL_A_OFS, 32'hB0);
        repeat (8) @(posedge clk);
        rdr(cmp_ctrl_pkg::RESULT_OFS);
        chk("inverted", rd[0], 1'b0);
        rdr(cmp_ctrl_pkg::IRQ_FLG_OFS);
        chk("fall masked", rd[0], 1'b0);
        wr(cmp_ctrl_pkg::CTRL_B_OFS, 32'h41);
        wr(cmp_ctrl_pkg::CTRL_A_OFS, 32'hA0);
        wr(cmp_ctrl_pkg::CTRL_A_OFS, 32'h20);
        repeat (8) @(posedge clk);
        chk("disabled gate", gate[0], 1'b0);
        rdr(cmp_ctrl_pkg::IRQ_FLG_OFS);
        chk("disable edge", rd[0], 1'b1);
        // here software syncs the result before it gates the timer; the first gate check ran with sync off
        wr(cmp_ctrl_pkg::IRQ_FLG_OFS, 32'h1);
        want <= 2'b00;
        wr(cmp_ctrl_pkg::CTRL_B_OFS, 32'h01);
        wr(cmp_ctrl_pkg::CTRL_A_OFS, 32'h81);
        repeat (8) @(posedge clk);
        want <= 2'b01;
        repeat (8) @(posedge clk);
        chk("sync held", {gate[0], pwm[0]}, 2'b01);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        repeat (8) @(posedge clk);
        chk("sync taken", gate[0], 1'b1);
        pins <= 8'($urandom);
        an = 8'($urandom);
        wr(cmp_ctrl_pkg::ANALOG_PIN_SELECT_OFS, 32'(an));
        repeat (4) @(posedge clk);
        rdr(cmp_ctrl_pkg::PORT_OFS);
        chk("port", rd[7:0], pins & ~an);
        print_verdict;
    end
    initial begin
        #200000;
        errors++;
        print_verdict;
    end
endmodule // analog_comparator_control_tb
